// >>> rtl/udma_consts.vh
`ifndef UDMA_CONSTS_VH
`define UDMA_CONSTS_VH

// ==========================================================
// channel mode setting fields
`define MODE_HI 4
`define MODE_LO 2
`define SIZE_HI 1
`define SIZE_LO 0
`define MODE_DST_INC 3'h0
`define MODE_DST_DEC 3'h1
`define MODE_SRC_INC 3'h2
`define MODE_SRC_DEC 3'h3
`define MODE_FIXED 3'h4
`define MODE_COUNTER 3'h5
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_QUAD 2'h2

// ==========================================================
// per-channel register select codes
`define SEL_SRC 3'h0
`define SEL_DST 3'h1
`define SEL_COUNT 3'h2
`define SEL_MODE 3'h3
`define SEL_VECTOR 3'h4

// ==========================================================
// widths and reset values
`define ADDR_W 24
`define COUNT_W 16
`define NUM_CH 4
`define COUNT_ONE 16'h0001
`define PTR_RST 32'h0000_0000
`define COUNT_RST 16'h0000
`define MODE_RST 8'h00
`define VEC_RST 8'h00
`define STEP_BYTE 32'h0000_0001
`define STEP_WORD 32'h0000_0002
`define STEP_QUAD 32'h0000_0004

// ==========================================================
// execution budgets in states (one state is one clock here)
`define BUDGET_SHORT 4'h8
`define BUDGET_QUAD 4'hc
`define BUDGET_COUNTER 4'h5
`define BUDGET_ONE 4'h1

// ==========================================================
// data buffer
`define FIFO_W 32
`define FIFO_D 4

`endif

// >>> rtl/udma_engine.v
`timescale 1ns/1ps
`default_nettype none
`include "udma_consts.vh"

// Behaviour
// - mode 000 post-increments destination pointer only
// - mode 001 post-decrements destination pointer only
// - mode 010 post-increments source pointer only
// - mode 011 post-decrements source pointer only
// - mode 100 leaves both pointers fixed
// - counter mode bumps source, counts, 5 states
// - each service decrements count; zero raises event
// - pointer updates follow the data move
// - byte/word take 8 states, quad 12
// - four channels with independent registers and events
// - sixteen-bit count, zero means 65536 services
// - pointers 32 bits, 24 drive address
// - count zero clears channel start vector
// - lowest numbered requesting channel with a start vector set wins
module udma_engine (
   // clock and reset
   input wire i_clk,
   input wire i_arst_n,
   // control register port
   input wire i_cfg_we,
   input wire i_cfg_re,
   input wire [1:0] i_cfg_ch,
   input wire [2:0] i_cfg_sel,
   input wire [31:0] i_cfg_wdata,
   output reg [31:0] o_cfg_rdata,
   // interrupt controller side
   input wire [3:0] i_req,
   output reg [3:0] o_accept,
   output reg [3:0] o_transfer_end_event,
   // system bus master
   output reg o_bus_rd,
   output reg o_bus_wr,
   output reg [23:0] o_bus_addr,
   output reg [1:0] o_bus_size,
   output reg [31:0] o_bus_wdata,
   input wire [31:0] i_bus_rdata,
   input wire i_bus_ack,
   // status
   output reg o_busy
);

   // ==========================================================
   // state machine codes, one-hot
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_READ = 5'h02;
   localparam [4:0] ST_WRITE = 5'h04;
   localparam [4:0] ST_UPD = 5'h08;
   localparam [4:0] ST_PAD = 5'h10;

   // ==========================================================
   // helpers
   // pointer step in bytes for a size code
   function [31:0] step_of;
      input [1:0] size;
      begin
         if (size == `SIZE_WORD) begin
            step_of = `STEP_WORD;
         end else if (size == `SIZE_QUAD) begin
            step_of = `STEP_QUAD;
         end else begin
            step_of = `STEP_BYTE;
         end
      end
   endfunction

   // post-update of a pointer: +step inc, -step dec, 0 hold
   function [31:0] bump;
      input [31:0] ptr;
      input [31:0] step;
      input inc;
      input dec;
      begin
         if (inc) begin
            bump = ptr + step;
         end else if (dec) begin
            bump = ptr - step;
         end else begin
            bump = ptr;
         end
      end
   endfunction

   // ==========================================================
   // channel register file
   reg [31:0] src_r [0:3]; // source pointers
   reg [31:0] dst_r [0:3]; // destination pointers
   reg [15:0] cnt_r [0:3]; // transfer counts
   reg [7:0] mode_r [0:3]; // channel mode settings
   reg [7:0] vec_r [0:3]; // channel start vectors

   // engine state
   reg [4:0] state_r; // current state
   reg [1:0] ch_r; // channel in service
   reg [3:0] cyc_r; // states spent on this service
   reg [3:0] budget_r; // states this service must take
   reg [3:0] end_hit_r; // channel finished this cycle

   // ==========================================================
   // request arbitration, lowest channel first
   wire [3:0] armed; // request with a start vector set
   reg found; // some channel is ready
   reg [1:0] pick; // winning channel
   integer k;
   assign armed = {vec_r[3] != `VEC_RST, vec_r[2] != `VEC_RST,
                   vec_r[1] != `VEC_RST, vec_r[0] != `VEC_RST} & i_req;

   always @* begin
      found = 1'b0;
      pick = 2'h0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (armed[k]) begin
            found = 1'b1;
            pick = k[1:0];
         end
      end
   end

   // ==========================================================
   // decode of the channel in service
   wire [2:0] cur_mode = mode_r[ch_r][`MODE_HI:`MODE_LO];
   wire [1:0] cur_size = mode_r[ch_r][`SIZE_HI:`SIZE_LO];
   wire [2:0] pick_mode = mode_r[pick][`MODE_HI:`MODE_LO];
   wire [1:0] pick_size = mode_r[pick][`SIZE_HI:`SIZE_LO];
   wire [31:0] cur_step = step_of(cur_size);
   wire [15:0] cnt_dec = cnt_r[ch_r] - `COUNT_ONE;

   // ==========================================================
   // data buffer between read and write cycles
   wire buf_in_ready; // room for a read word
   wire buf_out_valid; // a word waits for writing
   wire [31:0] buf_out_data; // oldest read word
   wire buf_push = (state_r == ST_READ) & i_bus_ack;
   wire buf_pop = (state_r == ST_WRITE) & ~o_bus_wr & buf_out_valid;

   udma_fifo #(
      .W(`FIFO_W),
      .D(`FIFO_D),
      .AW(2)
   ) u_buf (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_in_valid(buf_push),
      .o_in_ready(buf_in_ready),
      .i_in_data(i_bus_rdata),
      .o_out_valid(buf_out_valid),
      .i_out_ready(buf_pop),
      .o_out_data(buf_out_data)
   );

   // ==========================================================
   // engine sequencer and register updates
   integer c;
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (c = 0; c < `NUM_CH; c = c + 1) begin
            src_r[c] <= `PTR_RST;
            dst_r[c] <= `PTR_RST;
            cnt_r[c] <= `COUNT_RST;
            mode_r[c] <= `MODE_RST;
            vec_r[c] <= `VEC_RST;
         end
         state_r <= ST_IDLE;
         ch_r <= 2'h0;
         cyc_r <= 4'h0;
         budget_r <= `BUDGET_SHORT;
         end_hit_r <= 4'h0;
         o_accept <= 4'h0;
         o_transfer_end_event <= 4'h0;
         o_bus_rd <= 1'b0;
         o_bus_wr <= 1'b0;
         o_bus_addr <= 24'h00_0000;
         o_bus_size <= `SIZE_BYTE;
         o_bus_wdata <= 32'h0000_0000;
         o_busy <= 1'b0;
      end else begin
         o_accept <= 4'h0;
         o_transfer_end_event <= 4'h0;
         end_hit_r <= 4'h0;
         cyc_r <= cyc_r + 4'h1;
         case (state_r)
            // wait for an armed request
            ST_IDLE: begin
               cyc_r <= 4'h0;
               if (found) begin
                  ch_r <= pick;
                  o_accept[pick] <= 1'b1;
                  o_busy <= 1'b1;
                  cyc_r <= `BUDGET_ONE;
                  if (pick_mode == `MODE_COUNTER) begin
                     budget_r <= `BUDGET_COUNTER;
                     state_r <= ST_UPD;
                  end else begin
                     if (pick_size == `SIZE_QUAD) begin
                        budget_r <= `BUDGET_QUAD;
                     end else begin
                        budget_r <= `BUDGET_SHORT;
                     end
                     state_r <= ST_READ;
                  end
               end
            end
            // source read; waits for room in the buffer
            ST_READ: begin
               if (!o_bus_rd && buf_in_ready) begin
                  o_bus_rd <= 1'b1;
                  o_bus_addr <= src_r[ch_r][`ADDR_W-1:0];
                  o_bus_size <= cur_size;
               end else if (o_bus_rd && i_bus_ack) begin
                  o_bus_rd <= 1'b0;
                  state_r <= ST_WRITE;
               end
            end
            // destination write with the buffered word
            ST_WRITE: begin
               if (buf_pop) begin
                  o_bus_wr <= 1'b1;
                  o_bus_addr <= dst_r[ch_r][`ADDR_W-1:0];
                  o_bus_wdata <= buf_out_data;
               end else if (o_bus_wr && i_bus_ack) begin
                  o_bus_wr <= 1'b0;
                  state_r <= ST_UPD;
               end
            end
            // post-update pointers and count
            ST_UPD: begin
               src_r[ch_r] <= bump(src_r[ch_r],
                  (cur_mode == `MODE_COUNTER) ? `STEP_BYTE : cur_step,
                  (cur_mode == `MODE_SRC_INC) ||
                  (cur_mode == `MODE_COUNTER),
                  cur_mode == `MODE_SRC_DEC);
               dst_r[ch_r] <= bump(dst_r[ch_r], cur_step,
                  cur_mode == `MODE_DST_INC,
                  cur_mode == `MODE_DST_DEC);
               cnt_r[ch_r] <= cnt_dec;
               if (cnt_dec == `COUNT_RST) begin
                  end_hit_r[ch_r] <= 1'b1;
                  o_transfer_end_event[ch_r] <= 1'b1;
               end
               state_r <= ST_PAD;
            end
            // fill out the remaining execution states; busy spans budget
            ST_PAD: begin
               if (cyc_r >= budget_r) begin
                  o_busy <= 1'b0;
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
         // software register writes; a write lands after the engine
         if (i_cfg_we) begin
            if (i_cfg_sel == `SEL_SRC) begin
               src_r[i_cfg_ch] <= i_cfg_wdata;
            end else if (i_cfg_sel == `SEL_DST) begin
               dst_r[i_cfg_ch] <= i_cfg_wdata;
            end else if (i_cfg_sel == `SEL_COUNT) begin
               cnt_r[i_cfg_ch] <= i_cfg_wdata[`COUNT_W-1:0];
            end else if (i_cfg_sel == `SEL_MODE) begin
               mode_r[i_cfg_ch] <= i_cfg_wdata[7:0];
            end else if (i_cfg_sel == `SEL_VECTOR) begin
               vec_r[i_cfg_ch] <= i_cfg_wdata[7:0];
            end
         end
         // end of transfer disarms the channel unless software rearms
         for (c = 0; c < `NUM_CH; c = c + 1) begin
            if (end_hit_r[c] && !(i_cfg_we && i_cfg_sel == `SEL_VECTOR
                && i_cfg_ch == c[1:0])) begin
               vec_r[c] <= `VEC_RST;
            end
         end
      end
   end

   // ==========================================================
   // register read back, one cycle after the strobe
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_cfg_rdata <= 32'h0000_0000;
      end else if (i_cfg_re) begin
         if (i_cfg_sel == `SEL_SRC) begin
            o_cfg_rdata <= src_r[i_cfg_ch];
         end else if (i_cfg_sel == `SEL_DST) begin
            o_cfg_rdata <= dst_r[i_cfg_ch];
         end else if (i_cfg_sel == `SEL_COUNT) begin
            o_cfg_rdata <= {16'h0000, cnt_r[i_cfg_ch]};
         end else if (i_cfg_sel == `SEL_MODE) begin
            o_cfg_rdata <= {24'h00_0000, mode_r[i_cfg_ch]};
         end else if (i_cfg_sel == `SEL_VECTOR) begin
            o_cfg_rdata <= {24'h00_0000, vec_r[i_cfg_ch]};
         end else begin
            o_cfg_rdata <= 32'h0000_0000;
         end
      end
   end

endmodule

`default_nettype wire

// >>> rtl/udma_fifo.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// small synchronous fifo with valid/ready on both sides
module udma_fifo #(
   parameter W = 32,
   parameter D = 4,
   parameter AW = 2
) (
   // clock and reset
   input wire i_clk,
   input wire i_arst_n,
   // fill side
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [W-1:0] i_in_data,
   // drain side
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [W-1:0] o_out_data
);

   reg [W-1:0] mem_r [0:D-1]; // storage words
   reg [AW-1:0] wr_ptr_r; // next slot to fill
   reg [AW-1:0] rd_ptr_r; // oldest slot
   reg [AW:0] cnt_r; // words held
   wire push; // word taken in
   wire pop; // word handed out

   assign o_in_ready = (cnt_r != D[AW:0]);
   assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
   assign o_out_data = mem_r[rd_ptr_r];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;

   // storage write, no reset needed on data
   always @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   // pointer and occupancy bookkeeping
   always @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

// >>> verif/micro_dma_transfer_mode_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench for the transfer engine
module micro_dma_transfer_mode_engine_bench;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_cfg_we = 1'b0;
   logic i_cfg_re = 1'b0;
   logic [1:0] i_cfg_ch = 2'h0;
   logic [2:0] i_cfg_sel = 3'h0;
   logic [31:0] i_cfg_wdata = 32'h0;
   logic [3:0] raise = 4'h0;
   logic [1:0] bus_wait = 2'h0;
   wire [31:0] o_cfg_rdata, i_bus_rdata, o_bus_wdata;
   wire [3:0] i_req, o_accept, o_transfer_end_event;
   wire o_bus_rd, o_bus_wr, i_bus_ack, o_busy;
   wire [23:0] o_bus_addr;
   wire [1:0] o_bus_size;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [3:0] acc, ev; // accepts and end events seen
   int busy_n, nrd, nwr; // busy cycles and bus cycles seen
   logic [23:0] rda, wra;
   logic [31:0] wrd, d, src, dst;
   logic [1:0] wsz, ch;
   logic [15:0] cnt;
   int m, s;

   always #5 i_clk = ~i_clk;

   udma_engine u_dut (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_cfg_we(i_cfg_we), .i_cfg_re(i_cfg_re), .i_cfg_ch(i_cfg_ch),
      .i_cfg_sel(i_cfg_sel), .i_cfg_wdata(i_cfg_wdata),
      .o_cfg_rdata(o_cfg_rdata), .i_req(i_req), .o_accept(o_accept),
      .o_transfer_end_event(o_transfer_end_event), .o_bus_rd(o_bus_rd),
      .o_bus_wr(o_bus_wr), .o_bus_addr(o_bus_addr),
      .o_bus_size(o_bus_size), .o_bus_wdata(o_bus_wdata),
      .i_bus_rdata(i_bus_rdata), .i_bus_ack(i_bus_ack), .o_busy(o_busy));

   udma_bus_model u_far (.i_clk(i_clk), .i_arst_n(i_arst_n),
      .i_rd(o_bus_rd), .i_wr(o_bus_wr), .i_addr(o_bus_addr),
      .i_wait(bus_wait), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata),
      .i_raise(raise), .i_accept(o_accept), .o_req(i_req));

   // ==========================================================
   // checking and reporting
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // register port: one-cycle strobes at the falling edge
   task automatic reg_wr(input logic [1:0] c, input logic [2:0] sl,
                         input logic [31:0] v);
      @(negedge i_clk);
      i_cfg_we = 1'b1;
      i_cfg_ch = c;
      i_cfg_sel = sl;
      i_cfg_wdata = v;
      @(negedge i_clk);
      i_cfg_we = 1'b0;
   endtask

   task automatic reg_rd(input logic [1:0] c, input logic [2:0] sl,
                         output logic [31:0] v);
      @(negedge i_clk);
      i_cfg_re = 1'b1;
      i_cfg_ch = c;
      i_cfg_sel = sl;
      @(negedge i_clk);
      i_cfg_re = 1'b0;
      @(negedge i_clk);
      v = o_cfg_rdata;
   endtask

   // raise requests and watch one service to its end
   task automatic serve(input logic [3:0] r);
      int i;
      acc = 4'h0;
      ev = 4'h0;
      busy_n = 0;
      nrd = 0;
      nwr = 0;
      for (i = 0; i < 300; i++) begin
         @(negedge i_clk);
         raise = (i == 0) ? r : 4'h0;
         acc |= o_accept;
         ev |= o_transfer_end_event;
         if (o_busy === 1'b1) busy_n++;
         if (o_bus_rd && i_bus_ack) begin
            nrd++;
            rda = o_bus_addr;
         end
         if (o_bus_wr && i_bus_ack) begin
            nwr++;
            wra = o_bus_addr;
            wrd = o_bus_wdata;
            wsz = o_bus_size;
         end
         if (i > 1 && acc != 4'h0 && o_busy === 1'b0) break;
      end
      if (i == 300) begin
         error_cnt++;
         $display("ERROR service expected done seen timeout");
         tally_and_finish();
      end
   endtask

   // expected pointer after a service
   function automatic logic [31:0] moved(input logic [31:0] p,
      input logic up, dn, input logic [1:0] sz);
      if (up) return p + (32'h1 << sz);
      if (dn) return p - (32'h1 << sz);
      return p;
   endfunction

   function automatic int budget(input int md, sz);
      return (md == 5) ? 5 : ((sz == 2) ? 12 : 8);
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(32'h3851));
      repeat (4) @(negedge i_clk);
      i_arst_n = 1'b1;
      // reset values, and the unmapped select
      for (s = 0; s < 6; s++) begin
         reg_rd(s[1:0], s[2:0], d);
         check("reset value", d, 32'h0);
      end
      $display("reset values done");
      // every defined mode and size on a random channel; counter mode at byte size only
      for (m = 0; m < 6; m++) begin
         for (s = 0; s < 3; s++) begin
            if (m == 5 && s != 0) continue;
            ch = $urandom_range(3, 0);
            src = $urandom;
            dst = $urandom;
            cnt = $urandom_range(2, 0);
            bus_wait = $urandom_range(3, 0);
            reg_wr(ch, 3'h0, src);
            reg_wr(ch, 3'h1, dst);
            reg_wr(ch, 3'h2, {16'h0, cnt});
            reg_wr(ch, 3'h3, {24'h0, 3'h0, m[2:0], s[1:0]});
            reg_wr(ch, 3'h4, 32'h1);
            serve(4'h1 << ch);
            check("accept", acc, 4'h1 << ch);
            check("event", ev, (cnt == 1) ? 4'h1 << ch : 4'h0);
            check("bus cycles", nrd + nwr, (m == 5) ? 0 : 2);
            if (m != 5) begin
               check("read addr", rda, src[23:0]);
               check("write addr", wra, dst[23:0]);
               check("size", wsz, s);
               check("data", wrd & ((s == 2) ? 32'hffffffff :
                  ((s == 1) ? 32'hffff : 32'hff)),
                  {8'h5a, src[23:0]} & ((s == 2) ? 32'hffffffff :
                  ((s == 1) ? 32'hffff : 32'hff)));
            end
            if (bus_wait == 0) check("budget", busy_n, budget(m, s));
            else check("budget min", busy_n >= budget(m, s), 1);
            reg_rd(ch, 3'h0, d);
            check("source", d, moved(src, m == 2 || m == 5, m == 3,
               s[1:0]));
            reg_rd(ch, 3'h1, d);
            check("destination", d, moved(dst, m == 0, m == 1,
               s[1:0]));
            reg_rd(ch, 3'h2, d);
            check("count", d, {16'h0, cnt - 16'h1});
            reg_rd(ch, 3'h4, d);
            check("vector", d, (cnt == 1) ? 32'h0 : 32'h1);
         end
      end
      $display("mode table done");
      // two armed channels at once; disarmed ones are ignored
      bus_wait = 2'h0;
      for (s = 0; s < 4; s++) begin
         reg_wr(s[1:0], 3'h2, 32'h1);
         reg_wr(s[1:0], 3'h3, 32'h0);
         reg_wr(s[1:0], 3'h4, (s == 1 || s == 2) ? 32'h1 : 32'h0);
      end
      serve(4'hf);
      check("first winner", acc, 4'h2);
      serve(4'h0);
      check("second winner", acc, 4'h4);
      $display("priority done");
      tally_and_finish();
   end
endmodule

`default_nettype wire

// >>> verif/udma_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// far side: request flops and a memory bus with wait states
module udma_bus_model (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // engine bus side
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [23:0] i_addr,
   input wire logic [1:0] i_wait,
   output logic o_ack,
   output logic [31:0] o_rdata,
   // request flops
   input wire logic [3:0] i_raise,
   input wire logic [3:0] i_accept,
   output logic [3:0] o_req
);
   logic [1:0] wait_r; // idle cycles spent on this cycle

   // data only valid with ack, inverted otherwise
   assign o_rdata = o_ack ? {8'h5a, i_addr} : ~{8'h5a, i_addr};

   // requests stay until taken; ack pulses after i_wait cycles
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ack <= 1'b0;
         wait_r <= 2'h0;
         o_req <= 4'h0;
      end else begin
         o_req <= (o_req | i_raise) & ~i_accept;
         if (o_ack) begin
            o_ack <= 1'b0;
            wait_r <= 2'h0;
         end else if (i_rd || i_wr) begin
            // slow answers hold the engine off
            if (wait_r == i_wait) o_ack <= 1'b1;
            else wait_r <= wait_r + 2'h1;
         end
      end
   end
endmodule

`default_nettype wire

// >>> verif/udma_engine_properties.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port checker for the transfer engine
module udma_engine_properties (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_arst_n,
   // request side
   input wire logic [3:0] i_req,
   input wire logic [3:0] o_accept,
   input wire logic [3:0] o_transfer_end_event,
   // bus side
   input wire logic o_bus_rd,
   input wire logic o_bus_wr,
   input wire logic [23:0] o_bus_addr,
   input wire logic i_bus_ack,
   input wire logic o_busy
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_arst_n);

   // a data-moving service: accept, then the read cycle opens
   sequence move_start;
      (o_accept != 4'h0) ##1 o_bus_rd;
   endsequence

   a_accept_single: assert property ($onehot0(o_accept))
      else $error("more than one channel accepted");
   a_accept_cause: assert property ((o_accept != 4'h0) |->
      (($past(i_req) & o_accept) == o_accept))
      else $error("accept without a request");
   a_accept_busy: assert property ((o_accept != 4'h0) |-> o_busy)
      else $error("accept without busy");
   a_event_single: assert property ($onehot0(o_transfer_end_event))
      else $error("more than one end event");
   a_event_service: assert property ((o_transfer_end_event != 4'h0) |->
      $past(o_busy))
      else $error("end event outside a service");
   a_read_hold: assert property (o_bus_rd && !i_bus_ack |=>
      o_bus_rd && $stable(o_bus_addr))
      else $error("read dropped before ack");
   a_rdwr_excl: assert property (!(o_bus_rd && o_bus_wr))
      else $error("read and write together");
   a_write_follows: assert property ($fell(o_bus_rd) |-> ##[0:3] o_bus_wr)
      else $error("no write after read");
   a_budget_move: assert property (move_start |=> o_busy[*6])
      else $error("move shorter than budget");
   a_busy_min: assert property ($rose(o_busy) |-> o_busy[*5])
      else $error("service shorter than five states");
   a_busy_bound: assert property ($rose(o_busy) |-> ##[5:60] !o_busy)
      else $error("service never ends");
endmodule

bind udma_engine udma_engine_properties u_props (
   .i_clk(i_clk),
   .i_arst_n(i_arst_n),
   .i_req(i_req),
   .o_accept(o_accept),
   .o_transfer_end_event(o_transfer_end_event),
   .o_bus_rd(o_bus_rd),
   .o_bus_wr(o_bus_wr),
   .o_bus_addr(o_bus_addr),
   .i_bus_ack(i_bus_ack),
   .o_busy(o_busy)
);

`default_nettype wire
